// File: core/extint_detect.sv
/*
  External interrupt front end: non-maskable input edge, global mask,
  six sensed request pins (or a 4-bit encoded level), sixteen port pins,
  pending flags, all behind an AXI4-Lite slave.
  Assumes pins are asynchronous, cpu_block_bit is on aclk, and a
  priority stage downstream consumes the request outputs.
*/
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "extint_map.svh"

module extint_detect (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output extint_pkg::resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output extint_pkg::resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic nonmaskable_pin,
  input wire logic [5:0] external_request_pins,
  input wire logic [15:0] port_interrupt_pins,
  input wire logic cpu_block_bit,
  output logic nmi_request,
  output logic [5:0] ext_request_out,
  output logic [3:0] encoded_level_out,
  output logic [1:0] port_group_out,
  output logic block_all_out
);
  import extint_pkg::*;

  localparam int NP = 1 + `NUM_EXT + `NUM_PORT;

  pin_sync_if #(.W(NP)) ps ();
  logic nmi_lvl;
  logic nmi_prev;
  logic [5:0] ext_lvl;
  logic [5:0] ext_prev;
  logic [15:0] port_lvl;

  pin_sync #(.W(NP)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins({port_interrupt_pins, external_request_pins, nonmaskable_pin}),
    .sync(ps)
  );

  assign nmi_lvl = ps.lvl[0];
  assign nmi_prev = ps.prev[0];
  assign ext_lvl = ps.lvl[6:1];
  assign ext_prev = ps.prev[6:1];
  assign port_lvl = ps.lvl[NP-1:7];

  // registers
  logic edge_sel_ff, nxt_edge_sel;
  reg16_t erc_ff, nxt_erc;
  reg16_t prp_ff, nxt_prp;
  reg16_t pre_ff, nxt_pre;
  logic [5:0] flag_ff, nxt_flag;
  logic [1:0] grp_ff, nxt_grp;
  logic awready_ff, nxt_awready;
  logic bvalid_ff, nxt_bvalid;
  resp_t bresp_ff, nxt_bresp;
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  resp_t rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic nmi_req_ff, nxt_nmi_req;
  logic [5:0] ext_out_ff, nxt_ext_out;
  logic [3:0] enc_out_ff, nxt_enc_out;
  logic [1:0] grp_out_ff, nxt_grp_out;
  logic block_ff, nxt_block;

  logic wr_en;
  logic [15:0] lane_mask;
  logic wr_flags;
  logic mask_bit;
  logic lvl_sel;
  logic blk_ovr;
  logic nmi_edge;
  logic nmi_ok;
  logic block_all;
  logic [5:0] edge_hit;
  logic [5:0] low_mode;
  logic [5:0] encoded;
  logic [15:0] port_hit;

  assign mask_bit = erc_ff[`ERC_MASK_BIT];
  assign lvl_sel = erc_ff[`ERC_LVLSEL_BIT];
  assign blk_ovr = erc_ff[`ERC_BLKOVR_BIT];
  // write is committed on the edge where awready/wready are high
  assign wr_en = awready_ff;
  assign lane_mask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign wr_flags = wr_en && s_axi_awaddr == `ERF_OFS && s_axi_wstrb[0];

  // non-maskable edge, masking and global block
  always_comb begin
    nmi_edge = edge_sel_ff ? (nmi_lvl && !nmi_prev)
                           : (!nmi_lvl && nmi_prev);
    nmi_ok = !mask_bit && (!cpu_block_bit || blk_ovr);
    block_all = mask_bit && !nmi_lvl;
  end

  // per-pin sense decode; encoded mode takes pins 0..3 away from flags
  for (genvar i = 0; i < `NUM_EXT; i++) begin : g_sense
    sense_e sense;
    assign sense = sense_e'(erc_ff[2*i+1:2*i]);
    assign encoded[i] = lvl_sel && (i < `NUM_ENC);
    assign low_mode[i] = sense == SENSE_LOW;
    assign edge_hit[i] = (sense == SENSE_FALL && !ext_lvl[i] && ext_prev[i]) ||
                         (sense == SENSE_RISE && ext_lvl[i] && !ext_prev[i]);
  end

  // port pins: level compare, then enable gate
  assign port_hit = ~(port_lvl ^ prp_ff) & pre_ff;

  // flag next values; hardware set beats a software clear
  always_comb begin
    nxt_flag = flag_ff;
    for (int i = 0; i < `NUM_EXT; i++) begin
      if (encoded[i]) begin
        nxt_flag[i] = 1'b0;
      end else if (low_mode[i]) begin
        nxt_flag[i] = !ext_lvl[i];
      end else if (edge_hit[i]) begin
        nxt_flag[i] = 1'b1;
      end else if (wr_flags && !s_axi_wdata[i]) begin
        nxt_flag[i] = 1'b0;
      end
    end
    nxt_grp = {|port_hit[15:8], |port_hit[7:0]};
  end

  // control register writes, lane by lane
  always_comb begin
    nxt_edge_sel = edge_sel_ff;
    nxt_erc = erc_ff;
    nxt_prp = prp_ff;
    nxt_pre = pre_ff;
    if (wr_en) begin
      unique case (s_axi_awaddr)
        `NMC_OFS: begin
          if (s_axi_wstrb[1]) begin
            nxt_edge_sel = s_axi_wdata[`NMC_EDGE_BIT];
          end
        end
        `ERC_OFS: begin
          nxt_erc = (erc_ff & ~lane_mask) | (s_axi_wdata[15:0] & lane_mask & `ERC_WMASK);
        end
        `PRP_OFS: begin
          nxt_prp = (prp_ff & ~lane_mask) | (s_axi_wdata[15:0] & lane_mask);
        end
        `PRE_OFS: begin
          nxt_pre = (pre_ff & ~lane_mask) | (s_axi_wdata[15:0] & lane_mask);
        end
        default: begin
        end
      endcase
    end
  end

  // write channel: take address and data together, answer one cycle later
  always_comb begin
    nxt_awready = s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (wr_en) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = (s_axi_awaddr[1:0] == 2'h0 && s_axi_awaddr <= `ERF_OFS) ?
                  `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // read channel; unmapped reads return zero with a slave error
  always_comb begin
    nxt_arready = s_axi_arvalid && !arready_ff && !rvalid_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `RESP_OKAY;
      nxt_rdata = 32'h0;
      unique case (s_axi_araddr)
        `NMC_OFS: begin
          nxt_rdata[`NMC_LEVEL_BIT] = nmi_lvl;
          nxt_rdata[`NMC_EDGE_BIT] = edge_sel_ff;
        end
        `ERC_OFS: nxt_rdata[15:0] = erc_ff;
        `PRP_OFS: nxt_rdata[15:0] = prp_ff;
        `PRE_OFS: nxt_rdata[15:0] = pre_ff;
        `ERF_OFS: nxt_rdata[7:0] = {grp_ff[0], grp_ff[1], flag_ff};
        default: nxt_rresp = `RESP_SLVERR;
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // request outputs toward the priority stage; request, encoded and group outputs gated by the global block, the non-maskable one by the mask bit
  always_comb begin
    nxt_block = block_all;
    nxt_nmi_req = nmi_edge && nmi_ok;
    nxt_ext_out = block_all ? 6'h0 : flag_ff;
    nxt_enc_out = (block_all || !lvl_sel) ? 4'h0 : ~ext_lvl[3:0];
    nxt_grp_out = block_all ? 2'h0 : grp_ff;
  end

  // standby is not modelled as a reset: only aresetn clears state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_sel_ff <= 1'b0;
      erc_ff <= `ERC_RESET;
      prp_ff <= `PRP_RESET;
      pre_ff <= `PRE_RESET;
      {grp_ff, flag_ff} <= `ERF_RESET;
      awready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= `RESP_OKAY;
      rdata_ff <= 32'h0;
      nmi_req_ff <= 1'b0;
      ext_out_ff <= 6'h0;
      enc_out_ff <= 4'h0;
      grp_out_ff <= 2'h0;
      block_ff <= 1'b0;
    end else begin
      edge_sel_ff <= nxt_edge_sel;
      erc_ff <= nxt_erc;
      prp_ff <= nxt_prp;
      pre_ff <= nxt_pre;
      flag_ff <= nxt_flag;
      grp_ff <= nxt_grp;
      awready_ff <= nxt_awready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      nmi_req_ff <= nxt_nmi_req;
      ext_out_ff <= nxt_ext_out;
      enc_out_ff <= nxt_enc_out;
      grp_out_ff <= nxt_grp_out;
      block_ff <= nxt_block;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = awready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign nmi_request = nmi_req_ff;
  assign ext_request_out = ext_out_ff;
  assign encoded_level_out = enc_out_ff;
  assign port_group_out = grp_out_ff;
  assign block_all_out = block_ff;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic rd_nmc;
  logic rd_erf;
  assign rd_nmc = arready_ff && s_axi_araddr == `NMC_OFS;
  assign rd_erf = arready_ff && s_axi_araddr == `ERF_OFS;

  nmi_rise_a: assert property (edge_sel_ff && nmi_lvl && !nmi_prev && nmi_ok |=> nmi_request)
    else $error("rising edge missed");
  nmi_fall_a: assert property (!edge_sel_ff && !nmi_lvl && nmi_prev && nmi_ok
    |=> nmi_request)
    else $error("falling edge missed");
  nmi_level_a: assert property (rd_nmc |=> s_axi_rdata[15] == $past(nmi_lvl))
    else $error("pin level bit wrong");
  nmc_rsvd_a: assert property (rd_nmc
    |=> s_axi_rdata[14:9] == 6'h0 && s_axi_rdata[7:0] == 8'h0)
    else $error("reserved bits not zero");
  mask_nmi_a: assert property (mask_bit |=> !nmi_request)
    else $error("masked request passed");
  block_all_a: assert property (mask_bit && !nmi_lvl
    |=> block_all_out && ext_request_out == 6'h0 && port_group_out == 2'h0)
    else $error("global block failed");
  encoded_mode_a: assert property (lvl_sel ##1 lvl_sel |-> flag_ff[3:0] == 4'h0)
    else $error("encoded pins set flags");
  blk_override_a: assert property (nmi_edge && cpu_block_bit && !blk_ovr |=> !nmi_request)
    else $error("block bit ignored");
  rsvd_bit12_a: assert property (!erc_ff[12])
    else $error("reserved bit set");
  reg_reset_a: assert property (disable iff (1'b0) !aresetn
    |=> erc_ff == `ERC_RESET && prp_ff == 16'h0 && pre_ff == 16'h0
    && {grp_ff, flag_ff} == 8'h0)
    else $error("reset value wrong");
  port_enable_a: assert property (pre_ff == 16'h0 |=> grp_ff == 2'h0)
    else $error("disabled pin flagged");
  port_group_a: assert property (|port_hit[7:0] |=> grp_ff[0])
    else $error("group low not flagged");
  flag_read_a: assert property (rd_erf
    |=> s_axi_rdata[7] == $past(grp_ff[0]) && s_axi_rdata[6] == $past(grp_ff[1]))
    else $error("flag read wrong");
  // request output trails the flag by one register stage
  for (genvar i = 0; i < `NUM_EXT; i++) begin : g_chk
    edge_set_a: assert property (!encoded[i] && edge_hit[i]
      |=> flag_ff[i] ##1 (ext_request_out[i] || block_all_out))
      else $error("edge not flagged");
    edge_hold_a: assert property (!encoded[i] && !low_mode[i] && flag_ff[i]
      && !(wr_flags && !s_axi_wdata[i]) |=> flag_ff[i])
      else $error("edge flag lost");
    write_one_a: assert property (!encoded[i] && !low_mode[i] && !flag_ff[i]
      && !edge_hit[i] |=> !flag_ff[i])
      else $error("flag set without edge");
    level_flag_a: assert property (!encoded[i] && low_mode[i]
      |=> flag_ff[i] == !$past(ext_lvl[i]))
      else $error("level flag wrong");
    read_flag_a: assert property (rd_erf |=> s_axi_rdata[i] == $past(flag_ff[i]))
      else $error("request flag read wrong");
  end

  nmi_seen_c: cover property (nmi_request);
  flag_clear_c: cover property (wr_flags && flag_ff[0] ##1 !flag_ff[0]);
  block_c: cover property (block_all_out);
  encoded_c: cover property (encoded_level_out != 4'h0);
endmodule
`default_nettype wire

// File: core/extint_map.svh
/*
  Register offsets, field positions and reset values of the external
  interrupt front end. Assumes a byte-addressed AXI4-Lite slave with 32-bit data.
*/
`ifndef EXTINT_MAP_SVH
`define EXTINT_MAP_SVH
`define NMC_OFS 8'h00
`define ERC_OFS 8'h04
`define PRP_OFS 8'h08
`define PRE_OFS 8'h0c
`define ERF_OFS 8'h10
`define NMC_LEVEL_BIT 15
`define NMC_EDGE_BIT 8
`define ERC_MASK_BIT 15
`define ERC_LVLSEL_BIT 14
`define ERC_BLKOVR_BIT 13
`define ERC_WMASK 16'hefff
`define ERC_RESET 16'h4000
`define PRP_RESET 16'h0000
`define PRE_RESET 16'h0000
`define ERF_RESET 8'h00
`define NUM_EXT 6
`define NUM_PORT 16
`define NUM_ENC 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: core/extint_pkg.sv
/*
  Types shared by the external interrupt front end.
  Assumes extint_map.svh supplies the numeric constants.
*/
package extint_pkg;
  // two-bit sense code of one external request pin
  typedef enum logic [1:0] {
    SENSE_FALL = 2'h0,
    SENSE_RISE = 2'h1,
    SENSE_LOW = 2'h2,
    SENSE_RSVD = 2'h3
  } sense_e;
  typedef logic [1:0] resp_t;
  typedef logic [15:0] reg16_t;
endpackage

// File: core/pin_sync.sv
/*
  Two-stage synchroniser for asynchronous pins, plus one delayed copy for
  edge detection. Assumes pins are asynchronous to aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 23
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] pins,
  pin_sync_if.src sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] lvl_ff;
  logic [W-1:0] prev_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_lvl;
  logic [W-1:0] nxt_prev;

  // first stage feeds only the second stage
  always_comb begin
    nxt_meta = pins;
    nxt_lvl = meta_ff;
    nxt_prev = lvl_ff;
  end

  // reset to high: idle level of active-low pins, so no false edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= '1;
      lvl_ff <= '1;
      prev_ff <= '1;
    end else begin
      meta_ff <= nxt_meta;
      lvl_ff <= nxt_lvl;
      prev_ff <= nxt_prev;
    end
  end

  assign sync.lvl = lvl_ff;
  assign sync.prev = prev_ff;
endmodule
`default_nettype wire

// File: core/pin_sync_if.sv
/*
  Synchronised pin levels passed from the synchroniser to the detector.
  Assumes one clock for both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if #(parameter int W = 23);
  logic [W-1:0] lvl;
  logic [W-1:0] prev;
  modport src (output lvl, output prev);
  modport dst (input lvl, input prev);
endinterface
`default_nettype wire

// File: verif/pin_source.sv
/*
  Behavioural source of the external interrupt pins: non-maskable pin,
  six request pins and sixteen port pins.
  Assumes the bench calls drive() from its main thread, right after an edge.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic aclk,
  output logic nonmaskable_pin,
  output logic [5:0] external_request_pins,
  output logic [15:0] port_interrupt_pins
);
  // idle high, as if pulled up, so no edge is seen out of reset
  initial begin
    nonmaskable_pin = 1'b1;
    external_request_pins = 6'h3f;
    port_interrupt_pins = 16'hffff;
  end

  // new levels just after an edge, then held: a short hold acts as a
  // prompt source, a long one as a slow source; never under two cycles
  task automatic drive(input logic n, input logic [5:0] r, input logic [15:0] p,
                       input int hold);
    @(posedge aclk);
    nonmaskable_pin <= n;
    external_request_pins <= r;
    port_interrupt_pins <= p;
    repeat (hold) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

// File: verif/tb_external_interrupt_input_detect.sv
/*
  Self-checking bench of the external interrupt front end: AXI4-Lite
  register tasks, pin stimulus through the pin source model.
  Assumes the offsets and codes of extint_map.svh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "extint_map.svh"
module tb_external_interrupt_input_detect;
  import extint_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic cpu_block_bit = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, nmi_pin, nmi_request, block_all_out;
  logic [31:0] rdata;
  logic [31:0] rd;
  resp_t bresp, rresp, rs;
  logic [5:0] req_pins, ext_request_out;
  logic [15:0] port_pins;
  logic [3:0] encoded_level_out;
  logic [1:0] port_group_out;
  int fails = 0;
  int cmp_count = 0;
  int nmi_cnt = 0;

  extint_detect i_extint_detect (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .nonmaskable_pin(nmi_pin), .external_request_pins(req_pins),
    .port_interrupt_pins(port_pins), .cpu_block_bit(cpu_block_bit),
    .nmi_request(nmi_request), .ext_request_out(ext_request_out),
    .encoded_level_out(encoded_level_out), .port_group_out(port_group_out),
    .block_all_out(block_all_out)
  );

  pin_source i_pin_source (
    .aclk(aclk), .nonmaskable_pin(nmi_pin), .external_request_pins(req_pins),
    .port_interrupt_pins(port_pins)
  );

  // 200 mhz clock
  always #2.5 aclk = ~aclk;

  // count one-cycle non-maskable pulses; a missed or doubled pulse shows here
  always @(posedge aclk) begin
    if (nmi_request === 1'b1) nmi_cnt <= nmi_cnt + 1;
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  // one write; starts on a fresh edge so no signal is set twice in a step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input resp_t er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (n >= 50) begin
      fails++;
      summarize();
    end
    check("bresp", er, bresp);
  endtask

  // one read; data and response taken at the edge where rvalid is seen
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output resp_t r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) begin
      fails++;
      summarize();
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string name);
    rd_reg(a, rd, rs);
    check(name, e, rd);
    check("rresp", `RESP_OKAY, rs);
  endtask

  task automatic pins(input logic n, input logic [5:0] r, input logic [15:0] p, input int h);
    i_pin_source.drive(n, r, p, h);
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values; pin idles high
    rchk(`NMC_OFS, 32'h8000, "nmc");
    rchk(`ERC_OFS, 32'h4000, "erc");
    rchk(`PRP_OFS, 32'h0, "prp");
    rchk(`PRE_OFS, 32'h0, "pre");
    rchk(`ERF_OFS, 32'h0, "erf");
    rd_reg(8'h14, rd, rs);
    check("unmapped_rresp", `RESP_SLVERR, rs);
    wr(8'h14, 32'hffff, `RESP_SLVERR);
    // reserved bits hold zero
    wr(`NMC_OFS, 32'hffff, `RESP_OKAY);
    rchk(`NMC_OFS, 32'h8100, "nmc_rsvd");
    wr(`ERC_OFS, 32'hffff, `RESP_OKAY);
    rchk(`ERC_OFS, 32'hefff, "erc_rsvd");
    // req0 fall, req1 rise, req2 low level, independent pins
    wr(`ERC_OFS, 32'h0024, `RESP_OKAY);
    // rising edge select
    pins(1'b0, 6'h3f, 16'hffff, 8);
    pins(1'b1, 6'h3f, 16'hffff, 8);
    check("nmi_rise", 1, nmi_cnt);
    wr(`NMC_OFS, 32'h0, `RESP_OKAY);
    pins(1'b0, 6'h3f, 16'hffff, 8);
    rchk(`NMC_OFS, 32'h0, "nmc_low");
    pins(1'b1, 6'h3f, 16'hffff, 8);
    check("nmi_fall", 2, nmi_cnt);
    // global mask
    wr(`ERC_OFS, 32'h8024, `RESP_OKAY);
    pins(1'b0, 6'h3f, 16'hffff, 8);
    check("block_all", 1, block_all_out);
    check("nmi_masked", 2, nmi_cnt);
    pins(1'b1, 6'h3f, 16'hffff, 8);
    check("block_free", 0, block_all_out);
    // cpu block bit with and without override
    wr(`ERC_OFS, 32'h0024, `RESP_OKAY);
    cpu_block_bit <= 1'b1;
    pins(1'b0, 6'h3f, 16'hffff, 8);
    pins(1'b1, 6'h3f, 16'hffff, 8);
    check("nmi_blocked", 2, nmi_cnt);
    wr(`ERC_OFS, 32'h2024, `RESP_OKAY);
    pins(1'b0, 6'h3f, 16'hffff, 8);
    check("nmi_override", 3, nmi_cnt);
    cpu_block_bit <= 1'b0;
    pins(1'b1, 6'h3f, 16'hffff, 8);
    // short pulse on req1..0: fall latches req0, rise latches req1
    pins(1'b1, 6'h3c, 16'hffff, 3);
    pins(1'b1, 6'h3f, 16'hffff, 8);
    rchk(`ERF_OFS, 32'h03, "erf_edge");
    check("ext_out", 6'h03, ext_request_out);
    wr(`ERF_OFS, 32'hff, `RESP_OKAY);
    rchk(`ERF_OFS, 32'h03, "erf_w1");
    wr(`ERF_OFS, 32'h02, `RESP_OKAY);
    rchk(`ERF_OFS, 32'h02, "erf_w0");
    wr(`ERF_OFS, 32'h0, `RESP_OKAY);
    rchk(`ERF_OFS, 32'h0, "erf_clr");
    // level sense follows the pin
    pins(1'b1, 6'h3b, 16'hffff, 8);
    rchk(`ERF_OFS, 32'h04, "erf_lvl");
    check("ext_lvl", 6'h04, ext_request_out);
    pins(1'b1, 6'h3f, 16'hffff, 8);
    rchk(`ERF_OFS, 32'h0, "erf_lvl_off");
    // encoded level mode, pins active low
    wr(`ERC_OFS, 32'h4000, `RESP_OKAY);
    pins(1'b1, 6'h35, 16'hffff, 8);
    check("encoded", 4'ha, encoded_level_out);
    rchk(`ERF_OFS, 32'h0, "erf_enc");
    pins(1'b1, 6'h3f, 16'hffff, 8);
    // port pins: pin8 high-active, pin0 low-active
    wr(`PRP_OFS, 32'h0100, `RESP_OKAY);
    wr(`PRE_OFS, 32'h0101, `RESP_OKAY);
    rchk(`PRP_OFS, 32'h0100, "prp_rw");
    rchk(`PRE_OFS, 32'h0101, "pre_rw");
    rchk(`ERF_OFS, 32'h40, "erf_grp1");
    check("grp_hi", 2'b10, port_group_out);
    pins(1'b1, 6'h3f, 16'hfffe, 8);
    rchk(`ERF_OFS, 32'hc0, "erf_grp");
    check("grp_both", 2'b11, port_group_out);
    wr(`PRE_OFS, 32'h0, `RESP_OKAY);
    rchk(`ERF_OFS, 32'h0, "erf_grp_off");
    check("grp_off", 2'b00, port_group_out);
    summarize();
  end
endmodule
`default_nettype wire
